// [hdl/flash_cmd_regs.svh]
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH
// Register byte addresses
`define OFS_STATUS 28'hFFFF800
`define OFS_MODE   28'hFFFF804
`define OFS_CMD    28'hFFFF808
`define OFS_DATA   28'hFFFF80C
`define OFS_ADDR   28'hFFFF810
`define OFS_SIGN   28'hFFFF818
`define OFS_PROT   28'hFFFF81C
// Reset values
`define MODE_RST   16'h0000
`define CMD_RST    8'h07
// Mode register fields
`define MODE_IRQ_EN 4
`define MODE_WR_EN  3
`define MODE_KEY_HI 7
`define MODE_KEY_LO 5
`define MODE_KEY_VAL 3'h5
// Command codes
`define CMD_NULL   8'h00
`define CMD_READ   8'h01
`define CMD_WRITE  8'h02
`define CMD_ERW    8'h03
`define CMD_VERIFY 8'h04
`define CMD_ERASE  8'h05
`define CMD_MASS   8'h06
`define CMD_SIGN   8'h0B
`define CMD_PROT   8'h0C
// Status register bits
`define ST_DONE  0
`define ST_VFAIL 1
`define ST_BUSY  2
`define ST_REJ   3
`define ST_PLOCK 4
// Array geometry, in half-words
`define HW_LAST    15'h7FFF
`define HW_USER    15'h7C00
`define HW_USER_LAST 15'h7BFF
`define PAGE_LO    8'h00
`define PAGE_HI    8'hFF
`define ERASED_HW  16'hFFFF
// Boot configuration word and mass erase key
`define BOOT_CFG_IDX 15'h000A
`define BOOT_CFG_BLANK 32'hFFFFFFFF
`define MASS_KEY_ADDR 16'hFFC3
`define MASS_KEY_DATA 16'h3CFF
// Timing
`define CLK_PERIOD_NS 40
`define WRITE_TIME_NS 50000
`define ERW_TIME_US   24000
`define MASS_TIME_MS  2480
`define SIGN_CYCLES   32778
`endif

// [hdl/flash_cmd_pkg.sv]
package flash_cmd_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_READ, OP_PROG, OP_ERASE_PAGE,
    OP_ERASE_USER, OP_WALK, OP_PROTECT, OP_UNLOCK
  } array_op_t;

  typedef enum logic [2:0] {
    ST_LO_REQ, ST_LO_WAIT, ST_HI_REQ, ST_HI_WAIT, ST_IDLE, ST_RUN
  } ctrl_state_t;

  typedef struct packed {
    array_op_t   op;
    logic        busy;
    logic        done;
    logic        rvalid;
    logic [14:0] ptr;
    logic [14:0] last;
    logic [15:0] wd;
    logic [15:0] rdata;
    logic [31:0] prot;
    logic [31:0] key;
    logic        used;
  } arr_state_t;

  typedef struct packed {
    ctrl_state_t st;
    logic [15:0] mode;
    logic [7:0]  cmd;
    logic [15:0] data;
    logic [15:0] addr;
    logic [23:0] sign;
    logic [31:0] prot;
    logic [31:0] timer;
    logic [31:0] rdata;
    logic [15:0] boot_lo;
    array_op_t   op;
    logic [14:0] aidx;
    logic        op_start;
    logic        vfail;
    logic        done_f;
    logic        rej_f;
    logic        irq;
    logic        phase;
    logic        afin;
    logic        dl_mode;
    logic        boot_done;
    logic        bm_s1;
    logic        bm_s2;
  } ctl_state_t;
endpackage

// [hdl/flash_array.sv]
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"
module flash_array (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // Operation request
  input  wire flash_cmd_pkg::array_op_t op,
  input  wire logic                     op_start,
  input  wire logic [14:0]              idx,
  input  wire logic [15:0]              wdata,
  input  wire logic [31:0]              prot_in,
  input  wire logic [31:0]              key_in,
  // Results and stored protection
  output logic [15:0]                   rdata,
  output logic                          rvalid,
  output logic                          op_done,
  output logic [31:0]                   prot_nv,
  output logic [31:0]                   key_nv,
  output logic                          prot_used
);
  import flash_cmd_pkg::*;

  // Contents survive rst; an unwritten part starts fully erased
  logic [15:0] mem [0:`HW_LAST] = '{default: `ERASED_HW};
  // Protection words are nonvolatile too, so rst leaves them alone
  arr_state_t  s_r = '0;
  arr_state_t  s_nxt;
  logic        mem_we;
  logic [15:0] mem_wd;

  // One half-word per cycle from ptr up to last
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.rvalid = 1'b0;
    mem_we = 1'b0;
    mem_wd = `ERASED_HW;
    if (op_start) begin
      s_nxt.busy = 1'b1;
      s_nxt.op = op;
      s_nxt.wd = wdata;
      s_nxt.ptr = idx;
      s_nxt.last = idx;
      if (op == OP_ERASE_PAGE) begin
        s_nxt.ptr = {idx[14:8], `PAGE_LO};
        s_nxt.last = {idx[14:8], `PAGE_HI};
      end else if (op == OP_ERASE_USER) begin
        s_nxt.ptr = '0;
        s_nxt.last = `HW_USER_LAST;
      end else if (op == OP_WALK) begin
        s_nxt.ptr = '0;
        s_nxt.last = `HW_LAST;
      end
    end else if (s_r.busy) begin
      case (s_r.op)
        OP_READ, OP_WALK: begin
          s_nxt.rdata = mem[s_r.ptr];
          s_nxt.rvalid = 1'b1;
        end
        OP_PROG: begin
          // Programming can only clear bits
          mem_we = 1'b1;
          mem_wd = mem[s_r.ptr] & s_r.wd;
        end
        OP_ERASE_PAGE, OP_ERASE_USER: mem_we = 1'b1;
        OP_PROTECT: begin
          s_nxt.prot = prot_in;
          s_nxt.key = key_in;
          s_nxt.used = 1'b1;
        end
        OP_UNLOCK: begin
          s_nxt.prot = '0;
          s_nxt.used = 1'b0;
        end
        default: ;
      endcase
      if (s_r.op == OP_ERASE_USER) begin
        s_nxt.prot = '0;
        s_nxt.used = 1'b0;
      end
      if (s_r.ptr == s_r.last) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.ptr = s_r.ptr + 15'h0001;
      end
    end
  end

  // Volatile sequencing fields reset, stored words do not
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r.op <= OP_NONE;
      s_r.busy <= 1'b0;
      s_r.done <= 1'b0;
      s_r.rvalid <= 1'b0;
      s_r.ptr <= '0;
      s_r.last <= '0;
      s_r.wd <= '0;
      s_r.rdata <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Cell array write port
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[s_r.ptr] <= mem_wd;
    end
  end

  assign rdata = s_r.rdata;
  assign rvalid = s_r.rvalid;
  assign op_done = s_r.done;
  assign prot_nv = s_r.prot;
  assign key_nv = s_r.key;
  assign prot_used = s_r.used;
endmodule

// [hdl/flash_command_controller.sv]
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"
// Function
// - 62 kB user, 2 kB hidden firmware
// - Download mode: pin low, config word blank
// - Debug port active once boot check is done, unless download mode
// - Mode bit 4 gates completion interrupt
// - Mode bit 3 enables erase and write
// - Command register resets 0x07, 0x00 idles
// - Read loads half-word into data
// - Write programs data, about 50 us
// - Erase page then program, 24 ms
// - Verify result in status bit 1
// - Page erase clears one page
// - Mass erase clears user region, 2.48 s
// - Mass erase needs key sequence first
// - Signature over array, 32778 cycles
// - Protect commits once
// - Mass erase or key clears protection
module flash_command_controller #(
  parameter logic [31:0] ERW_CYCLES =
    32'(`ERW_TIME_US * 1000 / `CLK_PERIOD_NS),
  parameter logic [31:0] MASS_CYCLES =
    32'(`MASS_TIME_MS * 64'd1000000 / `CLK_PERIOD_NS),
  parameter logic [31:0] SIGN_CYCLES = 32'(`SIGN_CYCLES)
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [27:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Boot strap pin
  input  wire logic        boot_select_pin,
  // Status outputs
  output logic             flash_irq,
  output logic             flash_busy,
  output logic             download_mode,
  output logic             debug_port_en,
  output logic             boot_done
);
  import flash_cmd_pkg::*;

  localparam logic [31:0] WRITE_CYCLES = 32'((`WRITE_TIME_NS
    + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);

  ctl_state_t  s_r;
  ctl_state_t  s_nxt;
  logic [15:0] arr_rdata;
  logic        arr_rvalid;
  logic        arr_done;
  logic [31:0] prot_nv;
  logic [31:0] key_nv;
  logic        prot_used;
  logic        wr_cmd;
  logic [7:0]  code;
  logic        fw_hit;
  logic        blk_prot;
  logic        launch;
  array_op_t   lop;
  logic [31:0] ltime;
  logic        cmd_fin;

  flash_array u_array (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .op        (s_r.op),
    .op_start  (s_r.op_start),
    .idx       (s_r.aidx),
    .wdata     (s_r.data),
    .prot_in   (s_r.prot),
    .key_in    ({s_r.addr, s_r.data}),
    .rdata     (arr_rdata),
    .rvalid    (arr_rvalid),
    .op_done   (arr_done),
    .prot_nv   (prot_nv),
    .key_nv    (key_nv),
    .prot_used (prot_used)
  );

  // Address checks use the registers as they stood before this cycle
  assign wr_cmd = reg_wr && (reg_addr == `OFS_CMD);
  assign code = reg_wdata[7:0];
  assign fw_hit = (s_r.addr[15:1] >= `HW_USER);
  assign blk_prot = prot_nv[s_r.addr[15:11]];

  // Command decode, only looked at while idle
  always_comb begin
    launch = 1'b0;
    lop = OP_NONE;
    ltime = '0;
    case (code)
      `CMD_READ, `CMD_VERIFY: begin
        launch = !fw_hit;
        lop = OP_READ;
      end
      `CMD_WRITE: begin
        launch = s_r.mode[`MODE_WR_EN] && !fw_hit && !blk_prot;
        lop = OP_PROG;
        ltime = WRITE_CYCLES;
      end
      `CMD_ERW, `CMD_ERASE: begin
        launch = s_r.mode[`MODE_WR_EN] && !fw_hit && !blk_prot;
        lop = OP_ERASE_PAGE;
        ltime = (code == `CMD_ERW) ? ERW_CYCLES : '0;
      end
      `CMD_MASS: begin
        launch = s_r.mode[`MODE_WR_EN] && (s_r.addr == `MASS_KEY_ADDR)
          && (s_r.data == `MASS_KEY_DATA);
        lop = OP_ERASE_USER;
        ltime = MASS_CYCLES;
      end
      `CMD_SIGN: begin
        launch = 1'b1;
        lop = OP_WALK;
        ltime = SIGN_CYCLES;
      end
      `CMD_PROT: begin
        // A second protect is only a key unlock attempt
        launch = !prot_used || ((s_r.mode[`MODE_KEY_HI:`MODE_KEY_LO]
          == `MODE_KEY_VAL) && ({s_r.addr, s_r.data} == key_nv));
        lop = prot_used ? OP_UNLOCK : OP_PROTECT;
      end
      default: ;
    endcase
  end

  // Next-state logic for the whole controller
  always_comb begin
    s_nxt = s_r;
    s_nxt.op_start = 1'b0;
    s_nxt.irq = 1'b0;
    s_nxt.bm_s1 = boot_select_pin;
    s_nxt.bm_s2 = s_r.bm_s1;
    s_nxt.rdata = '0;
    cmd_fin = 1'b0;
    // Register reads; a status read clears the done and reject flags
    if (reg_rd) begin
      case (reg_addr)
        `OFS_STATUS: begin
          s_nxt.rdata[`ST_DONE] = s_r.done_f;
          s_nxt.rdata[`ST_VFAIL] = s_r.vfail;
          s_nxt.rdata[`ST_BUSY] = flash_busy;
          s_nxt.rdata[`ST_REJ] = s_r.rej_f;
          s_nxt.rdata[`ST_PLOCK] = prot_used;
          s_nxt.done_f = 1'b0;
          s_nxt.rej_f = 1'b0;
        end
        `OFS_MODE: s_nxt.rdata = {16'h0000, s_r.mode};
        `OFS_CMD:  s_nxt.rdata = {24'h000000, s_r.cmd};
        `OFS_DATA: s_nxt.rdata = {16'h0000, s_r.data};
        `OFS_ADDR: s_nxt.rdata = {16'h0000, s_r.addr};
        `OFS_SIGN: s_nxt.rdata = {8'h00, s_r.sign};
        `OFS_PROT: s_nxt.rdata = s_r.prot;
        default: ;
      endcase
    end
    // Register writes; operands are frozen while a command runs
    if (reg_wr) begin
      case (reg_addr)
        `OFS_MODE: s_nxt.mode = reg_wdata[15:0];
        `OFS_DATA: if (!flash_busy) s_nxt.data = reg_wdata[15:0];
        `OFS_ADDR: if (!flash_busy) s_nxt.addr = reg_wdata[15:0];
        `OFS_PROT: if (!flash_busy) s_nxt.prot = reg_wdata;
        default: ;
      endcase
    end
    unique case (s_r.st)
      // Boot check reads the two halves of the config word
      ST_LO_REQ, ST_HI_REQ: begin
        s_nxt.op = OP_READ;
        s_nxt.op_start = 1'b1;
        s_nxt.aidx = (s_r.st == ST_LO_REQ) ? `BOOT_CFG_IDX
          : `BOOT_CFG_IDX + 15'h0001;
        s_nxt.st = (s_r.st == ST_LO_REQ) ? ST_LO_WAIT : ST_HI_WAIT;
      end
      ST_LO_WAIT: if (arr_rvalid) begin
        s_nxt.boot_lo = arr_rdata;
        s_nxt.st = ST_HI_REQ;
      end
      ST_HI_WAIT: if (arr_rvalid) begin
        s_nxt.dl_mode = !s_r.bm_s2
          && ({arr_rdata, s_r.boot_lo} == `BOOT_CFG_BLANK);
        s_nxt.boot_done = 1'b1;
        s_nxt.st = ST_IDLE;
      end
      ST_IDLE: if (wr_cmd) begin
        if (code == `CMD_NULL) begin
          s_nxt.cmd = code;
        end else if (lop == OP_NONE) begin
          s_nxt.cmd = s_r.cmd;
        end else if (!launch) begin
          s_nxt.rej_f = 1'b1;
        end else begin
          s_nxt.cmd = code;
          s_nxt.st = ST_RUN;
          s_nxt.op = lop;
          s_nxt.op_start = 1'b1;
          s_nxt.aidx = s_r.addr[15:1];
          s_nxt.timer = ltime;
          s_nxt.phase = 1'b0;
          s_nxt.afin = 1'b0;
          if (lop == OP_WALK) begin
            s_nxt.sign = '0;
          end
        end
      end
      ST_RUN: begin
        // Writes to the command register are dropped here
        if (s_r.timer != '0) begin
          s_nxt.timer = s_r.timer - 32'd1;
        end
        if (arr_rvalid) begin
          if (s_r.cmd == `CMD_READ) begin
            s_nxt.data = arr_rdata;
          end else if (s_r.cmd == `CMD_VERIFY) begin
            s_nxt.vfail = (arr_rdata != s_r.data);
          end else begin
            s_nxt.sign = {s_r.sign[22:0], s_r.sign[23]}
              ^ {8'h00, arr_rdata};
          end
        end
        if (arr_done) begin
          if (s_r.cmd == `CMD_ERW && !s_r.phase) begin
            s_nxt.phase = 1'b1;
            s_nxt.op = OP_PROG;
            s_nxt.op_start = 1'b1;
          end else begin
            s_nxt.afin = 1'b1;
          end
        end
        // Finish only when the array is done and the time is spent
        if (s_r.afin && s_r.timer == '0) begin
          s_nxt.st = ST_IDLE;
          s_nxt.done_f = 1'b1;
          s_nxt.irq = s_r.mode[`MODE_IRQ_EN];
          cmd_fin = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= ST_LO_REQ;
      s_r.mode <= `MODE_RST;
      s_r.cmd <= `CMD_RST;
      s_r.op <= OP_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign flash_irq = s_r.irq;
  assign flash_busy = (s_r.st != ST_IDLE);
  assign download_mode = s_r.dl_mode;
  assign boot_done = s_r.boot_done;
  assign debug_port_en = s_r.boot_done && !s_r.dl_mode;

  // Checks on the controller's own behaviour
  AST_IRQ_GATE: assert property (@(posedge ref_clk)
    disable iff (rst) cmd_fin |=> flash_irq == $past(s_r.mode[`MODE_IRQ_EN]))
    else $error("completion interrupt does not follow enable bit");
  AST_IRQ_CAUSE: assert property (@(posedge ref_clk)
    disable iff (rst) flash_irq |-> $past(cmd_fin))
    else $error("interrupt without a completed command");
  AST_WR_LOCK: assert property (@(posedge ref_clk)
    disable iff (rst) (s_r.st == ST_IDLE && wr_cmd && !s_r.mode[`MODE_WR_EN]
     && (code == `CMD_WRITE || code == `CMD_ERASE || code == `CMD_MASS
     || code == `CMD_ERW)) |=> s_r.st == ST_IDLE && s_r.rej_f)
    else $error("erase or write ran while locked");
  AST_CMD_RESET: assert property (@(posedge ref_clk)
    $past(rst) && !rst |-> s_r.cmd == `CMD_RST && s_r.mode == `MODE_RST)
    else $error("command register reset value wrong");
  AST_READ_DATA: assert property (@(posedge ref_clk)
    disable iff (rst) (s_r.st == ST_RUN && s_r.cmd == `CMD_READ && arr_rvalid)
    |=> s_r.data == $past(arr_rdata))
    else $error("read result not loaded into data register");
  AST_WRITE_TIME: assert property (@(posedge ref_clk)
    disable iff (rst) s_r.op_start && s_r.cmd == `CMD_WRITE
    && s_r.st == ST_RUN |-> s_r.timer == WRITE_CYCLES)
    else $error("write time not loaded");
  AST_VERIFY: assert property (@(posedge ref_clk)
    disable iff (rst) s_r.st == ST_RUN && s_r.cmd == `CMD_VERIFY
    && arr_rvalid |=> s_r.vfail == ($past(arr_rdata) != s_r.data))
    else $error("verify outcome wrong");
  AST_FW_HIDDEN: assert property (@(posedge ref_clk)
    disable iff (rst) (s_r.op_start && s_r.boot_done && (s_r.op == OP_READ
     || s_r.op == OP_PROG || s_r.op == OP_ERASE_PAGE))
    |-> s_r.aidx < `HW_USER)
    else $error("user command reached firmware region");
  AST_MASS_KEY: assert property (@(posedge ref_clk)
    disable iff (rst) (s_r.op_start && s_r.op == OP_ERASE_USER) |-> s_r.addr
    == `MASS_KEY_ADDR && s_r.data == `MASS_KEY_DATA)
    else $error("mass erase without key sequence");
  AST_PROT_ONCE: assert property (@(posedge ref_clk)
    disable iff (rst) (s_r.op_start && s_r.op == OP_PROTECT) |-> !prot_used)
    else $error("protection committed twice");
  AST_RSVD: assert property (@(posedge ref_clk)
    disable iff (rst) (s_r.st == ST_IDLE && wr_cmd && code != `CMD_NULL
    && lop == OP_NONE) |=> s_r.st == ST_IDLE && $stable(s_r.cmd))
    else $error("reserved code changed state");
  AST_BUSY_DROP: assert property (@(posedge ref_clk)
    disable iff (rst) (flash_busy && wr_cmd) |=> $stable(s_r.cmd))
    else $error("command accepted while busy");
  AST_DEBUG: assert property (@(posedge ref_clk)
    disable iff (rst) $rose(s_r.boot_done) |-> debug_port_en != s_r.dl_mode)
    else $error("debug port state disagrees with boot decision");

  COV_WRITE: cover property (@(posedge ref_clk) disable iff (rst)
    cmd_fin && s_r.cmd == `CMD_WRITE);
  COV_VFAIL: cover property (@(posedge ref_clk) disable iff (rst)
    s_r.vfail);
  COV_REJECT: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(s_r.rej_f));
  COV_DLMODE: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(s_r.boot_done) && s_r.dl_mode);
endmodule

// [dv/flash_command_controller_tb.sv]
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"
module flash_command_controller_tb;
  import flash_cmd_pkg::*;

  logic        ref_clk;
  logic        rst;
  logic [27:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        boot_select_pin;
  logic        flash_irq;
  logic        flash_busy;
  logic        download_mode;
  logic        debug_port_en;
  logic        boot_done;
  logic        rd_d;
  int          err_count;
  int          cmp_count;
  int          irq_cnt;
  int          n;
  logic [31:0] seed;
  logic [15:0] d1;
  logic [15:0] d2;
  logic [23:0] sig;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  string       nm_q[$];

  // Erase counts shortened so the whole run stays short; signature count kept at 32778
  flash_command_controller #(
    .ERW_CYCLES  (32'd300),
    .MASS_CYCLES (32'd40000),
    .SIGN_CYCLES (32'd32778)
  ) i_flash_command_controller (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .boot_select_pin (boot_select_pin),
    .flash_irq       (flash_irq),
    .flash_busy      (flash_busy),
    .download_mode   (download_mode),
    .debug_port_en   (debug_port_en),
    .boot_done       (boot_done)
  );

  // 25 MHz clock
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One-cycle strobes; a free edge follows so strobes never merge
  task automatic wr(input logic [27:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read notes its expectation; the monitor compares one cycle later
  task automatic rd(input string nm, input logic [27:0] a,
                    input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    nm_q.push_back(nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
  endtask

  // Issue a command and wait, bounded, for busy to drop
  task automatic cmd(input logic [7:0] c, input int lim);
    int k;
    wr(`OFS_CMD, {24'h0, c});
    k = 0;
    @(posedge ref_clk);
    while (flash_busy !== 1'b0 && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= lim) chk("busy timeout", 32'd1, 32'd0);
    // One more edge so the pulse counter has seen the last cycle
    @(posedge ref_clk);
  endtask

  task automatic do_reset();
    int k;
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    k = 0;
    while (boot_done !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      k++;
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) begin
      chk(nm_q.pop_front(), reg_rdata & msk_q.pop_front(),
          exp_q.pop_front());
    end
  end

  // Completion pulses counted, not sampled, so none is missed
  always @(posedge ref_clk) begin
    if (flash_irq === 1'b1) irq_cnt++;
  end

  // Watchdog sized well above the mass erase plus signature walk
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    reg_addr = 28'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    boot_select_pin = 1'b1;
    rd_d = 1'b0;
    err_count = 0;
    cmp_count = 0;
    irq_cnt = 0;
    seed = 32'hEB19;
    do_reset();
    chk("download_mode", {31'h0, download_mode}, 32'h0);
    chk("debug_port_en", {31'h0, debug_port_en}, 32'h1);
    rd("mode reset", `OFS_MODE, 32'h0, 32'hFFFFFFFF);
    rd("cmd reset", `OFS_CMD, 32'h07, 32'hFFFFFFFF);
    rd("unmapped", 28'hFFFF8F0, 32'h0, 32'hFFFFFFFF);
    seed = xorshift(seed);
    d1 = seed[15:0];
    seed = xorshift(seed);
    d2 = seed[15:0];
    wr(`OFS_ADDR, 32'h0100);
    wr(`OFS_DATA, {16'h0, d1});
    cmd(`CMD_WRITE, 2000);
    rd("reject no wren", `OFS_STATUS, 32'h8, 32'h9);
    chk("irq masked", irq_cnt, 32'd0);
    wr(`OFS_MODE, 32'h18);
    cmd(`CMD_WRITE, 2000);
    chk("irq count", irq_cnt, 32'd1);
    rd("write done", `OFS_STATUS, 32'h1, 32'h9);
    wr(`OFS_DATA, 32'h0);
    cmd(`CMD_READ, 20);
    rd("read back", `OFS_DATA, {16'h0, d1}, 32'hFFFF);
    // The read reloaded the data register, so force a mismatch
    wr(`OFS_DATA, {16'h0, ~d1});
    cmd(`CMD_VERIFY, 20);
    rd("verify miss", `OFS_STATUS, 32'h2, 32'h2);
    wr(`OFS_DATA, {16'h0, d1});
    cmd(`CMD_VERIFY, 20);
    rd("verify match", `OFS_STATUS, 32'h0, 32'h2);
    cmd(`CMD_ERASE, 400);
    cmd(`CMD_READ, 20);
    rd("page erased", `OFS_DATA, 32'hFFFF, 32'hFFFF);
    wr(`OFS_DATA, {16'h0, d2});
    cmd(`CMD_ERW, 400);
    cmd(`CMD_READ, 20);
    rd("erase write", `OFS_DATA, {16'h0, d2}, 32'hFFFF);
    cmd(`CMD_NULL, 4);
    rd("null code", `OFS_CMD, 32'h0, 32'hFF);
    // Reserved codes and one past the last defined code
    for (int c = 7; c <= 13; c++) begin
      if (c == 11 || c == 12) continue;
      wr(`OFS_CMD, c);
      chk("reserved busy", {31'h0, flash_busy}, 32'h0);
      rd("reserved cmd", `OFS_CMD, 32'h0, 32'hFF);
    end
    rd("reserved data", `OFS_DATA, {16'h0, d2}, 32'hFFFF);
    // New command during a running one must be dropped
    wr(`OFS_CMD, {24'h0, `CMD_ERW});
    wr(`OFS_CMD, {24'h0, `CMD_ERASE});
    chk("busy high", {31'h0, flash_busy}, 32'h1);
    rd("cmd kept", `OFS_CMD, 32'h03, 32'hFF);
    rd("busy bit set", `OFS_STATUS, 32'h4, 32'h4);
    cmd(`CMD_NULL, 400);
    rd("busy bit", `OFS_STATUS, 32'h0, 32'h4);
    wr(`OFS_MODE, 32'h08);
    n = irq_cnt;
    cmd(`CMD_READ, 20);
    chk("irq off", irq_cnt, n);
    wr(`OFS_ADDR, 32'hF800);
    cmd(`CMD_READ, 20);
    rd("firmware hidden", `OFS_STATUS, 32'h8, 32'h8);
    wr(`OFS_ADDR, 32'h0100);
    wr(`OFS_PROT, 32'h1);
    cmd(`CMD_PROT, 20);
    rd("prot commit", `OFS_STATUS, 32'h10, 32'h18);
    wr(`OFS_DATA, 32'h0);
    cmd(`CMD_WRITE, 2000);
    rd("prot reject", `OFS_STATUS, 32'h18, 32'h18);
    cmd(`CMD_MASS, 50000);
    cmd(`CMD_READ, 20);
    rd("lone mass", `OFS_DATA, {16'h0, d2}, 32'hFFFF);
    wr(`OFS_ADDR, {16'h0, `MASS_KEY_ADDR});
    wr(`OFS_DATA, {16'h0, `MASS_KEY_DATA});
    cmd(`CMD_MASS, 50000);
    rd("prot cleared", `OFS_STATUS, 32'h0, 32'h10);
    wr(`OFS_ADDR, 32'h0100);
    cmd(`CMD_READ, 20);
    rd("mass erased", `OFS_DATA, 32'hFFFF, 32'hFFFF);
    // Whole array now reads erased, firmware part included
    sig = 24'h0;
    for (int i = 0; i < 32768; i++) begin
      sig = {sig[22:0], sig[23]} ^ {8'h0, `ERASED_HW};
    end
    cmd(`CMD_SIGN, 40000);
    rd("signature", `OFS_SIGN, {8'h0, sig}, 32'hFFFFFFFF);
    boot_select_pin <= 1'b0;
    do_reset();
    chk("download_mode", {31'h0, download_mode}, 32'h1);
    chk("debug_port_en", {31'h0, debug_port_en}, 32'h0);
    repeat (4) @(posedge ref_clk);
    end_of_test();
  end
endmodule
